//--- rtl/multidrop_scan_selection.v
// Level-1 selection logic of a multidrop scan bridge, sampling the test clock
`timescale 1ns/10ps
`include "scan_select_defines.vh"
module multidrop_scan_selection #(
	parameter [31:0] ID_VALUE = 32'h12345679, // Arbitrary identification value
	parameter MODE_WIDTH = 8
) (
	input wire clock,
	input wire nrst,
	input wire testClock,
	input wire testModeSelect,
	input wire backplaneSerialIn,
	input wire [5:0] slotAddress,
	input wire outputEnableN,
	output reg backplaneSerialOut,
	output reg backplaneSerialOutEnable,
	output reg [1:0] selectState,
	output reg [3:0] tapState,
	output reg unparkRequest,
	output reg [2:0] parkRequest,
	output wire [MODE_WIDTH-1:0] modeValue,
	output wire [1:0] groupValue,
	output reg signatureRun,
	output reg counterRun
);
	// ***************************************************************
	// Input synchronisers and test clock edge detection
	// ***************************************************************
	reg [1:0] tckSync, tmsSync, tdiSync;
	reg tckLast;
	always @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			// Idle pin levels, so no false test clock edge follows reset
			tckSync <= 2'h3;
			tmsSync <= 2'h3;
			tdiSync <= 2'h0;
			tckLast <= 1'b1;
		end else begin
			tckSync <= {tckSync[0], testClock};
			tmsSync <= {tmsSync[0], testModeSelect};
			tdiSync <= {tdiSync[0], backplaneSerialIn};
			tckLast <= tckSync[1];
		end
	end
	wire tckRise = tckSync[1] & ~tckLast;
	wire tckFall = ~tckSync[1] & tckLast;
	wire tms = tmsSync[1];
	wire tdi = tdiSync[1];

	// ***************************************************************
	// TAP controller
	// ***************************************************************
	function [3:0] tapNext;
		input [3:0] s;
		input m;
		begin
			case (s)
				`TAP_TLR: tapNext = m ? `TAP_TLR : `TAP_RTI;
				`TAP_RTI: tapNext = m ? `TAP_SELDR : `TAP_RTI;
				`TAP_SELDR: tapNext = m ? `TAP_SELIR : `TAP_CAPDR;
				`TAP_CAPDR: tapNext = m ? `TAP_EX1DR : `TAP_SHDR;
				`TAP_SHDR: tapNext = m ? `TAP_EX1DR : `TAP_SHDR;
				`TAP_EX1DR: tapNext = m ? `TAP_UPDR : `TAP_PDR;
				`TAP_PDR: tapNext = m ? `TAP_EX2DR : `TAP_PDR;
				`TAP_EX2DR: tapNext = m ? `TAP_UPDR : `TAP_SHDR;
				`TAP_UPDR: tapNext = m ? `TAP_SELDR : `TAP_RTI;
				`TAP_SELIR: tapNext = m ? `TAP_TLR : `TAP_CAPIR;
				`TAP_CAPIR: tapNext = m ? `TAP_EX1IR : `TAP_SHIR;
				`TAP_SHIR: tapNext = m ? `TAP_EX1IR : `TAP_SHIR;
				`TAP_EX1IR: tapNext = m ? `TAP_UPIR : `TAP_PIR;
				`TAP_PIR: tapNext = m ? `TAP_EX2IR : `TAP_PIR;
				`TAP_EX2IR: tapNext = m ? `TAP_UPIR : `TAP_SHIR;
				default: tapNext = m ? `TAP_SELDR : `TAP_RTI;
			endcase
		end
	endfunction
	always @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			tapState <= `TAP_TLR;
		end else if (tckRise) begin
			tapState <= tapNext(tapState, tms);
		end
	end
	wire inUpdateIr = (tapState == `TAP_UPIR);

	// ***************************************************************
	// Instruction register and data registers
	// ***************************************************************
	wire [7:0] irShift, instruction;
	wire irOut;
	reg [2:0] chain;
	wire selected = (selectState == `SEL_SINGLE) || (selectState == `SEL_MULTI);
	scan_shift_reg #(.WIDTH(`IR_WIDTH), .RESET_VALUE(`OP_IDCODE)) irReg (
		.clock(clock), .nrst(nrst), .step(tckRise),
		.capture(tapState == `TAP_CAPIR), .shift(tapState == `TAP_SHIR),
		.update(inUpdateIr), .captureValue(`IR_CAPTURE), .serialIn(tdi),
		.serialOut(irOut), .shiftValue(irShift), .parallelOut(instruction)
	);
	wire drStep = tckRise && selected;
	wire capDr = (tapState == `TAP_CAPDR);
	wire shDr = (tapState == `TAP_SHDR);
	wire upDr = (tapState == `TAP_UPDR);
	reg [31:0] idShift, cntShift, cntValue, sigShift;
	reg [6:0] bsShift;
	reg bypassBit;
	wire [1:0] grpShift;
	wire [MODE_WIDTH-1:0] modeShift;
	wire grpOut, modeOut;
	scan_shift_reg #(.WIDTH(2)) groupReg (
		.clock(clock), .nrst(nrst), .step(drStep && chain == `CH_GRP), .capture(capDr),
		.shift(shDr), .update(upDr), .captureValue(groupValue), .serialIn(tdi),
		.serialOut(grpOut), .shiftValue(grpShift), .parallelOut(groupValue)
	);
	scan_shift_reg #(.WIDTH(MODE_WIDTH)) modeReg (
		.clock(clock), .nrst(nrst), .step(drStep && chain == `CH_MODE), .capture(capDr),
		.shift(shDr), .update(upDr), .captureValue(modeValue), .serialIn(tdi),
		.serialOut(modeOut), .shiftValue(modeShift), .parallelOut(modeValue)
	);
	always @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			idShift <= 32'h0;
			bsShift <= 7'h0;
			bypassBit <= 1'b0;
			sigShift <= 32'h0;
			cntShift <= 32'h0;
			cntValue <= 32'h0;
		end else begin
			if (tckRise && counterRun && cntValue != 32'h0) begin
				cntValue <= cntValue - 32'h1;
			end
			if (drStep) begin
				case (chain)
					`CH_ID: idShift <= capDr ? ID_VALUE : shDr ? {tdi, idShift[31:1]} : idShift;
					`CH_BSR: bsShift <= capDr ? {outputEnableN, slotAddress} : shDr ? {tdi, bsShift[6:1]} : bsShift;
					`CH_BYP: bypassBit <= capDr ? 1'b0 : shDr ? tdi : bypassBit;
					`CH_SIG: sigShift <= shDr ? {tdi, sigShift[31:1]} : sigShift;
					`CH_CNT: begin
						if (capDr) begin
							cntShift <= cntValue;
						end else if (shDr) begin
							cntShift <= {tdi, cntShift[31:1]};
						end else if (upDr) begin
							cntValue <= cntShift;
						end
					end
					default: ;
				endcase
				if (signatureRun && shDr && chain != `CH_SIG) begin
					sigShift <= {sigShift[0] ^ sigShift[1] ^ sigShift[21] ^ sigShift[31] ^ tdi, sigShift[31:1]};
				end
			end
		end
	end

	// ***************************************************************
	// Selection controller
	// ***************************************************************
	wire [5:0] addr = irShift[5:0];
	wire isWait = (irShift == `OP_WAIT);
	always @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			selectState <= `SEL_WAIT;
		end else if (tckRise) begin
			if (tapState == `TAP_TLR) begin
				selectState <= `SEL_WAIT;
			end else if (inUpdateIr) begin
				if (isWait) begin
					selectState <= `SEL_WAIT;
				end else if (selectState == `SEL_WAIT) begin
					if (addr == `ADDR_BROADCAST) begin
						selectState <= `SEL_MULTI;
					end else if (addr >= `ADDR_GROUP_BASE) begin
						selectState <= (addr[1:0] == groupValue) ? `SEL_MULTI : `SEL_UNSEL;
					end else if (addr == slotAddress && addr <= `ADDR_DIRECT_MAX) begin
						selectState <= `SEL_SINGLE;
					end else begin
						selectState <= `SEL_UNSEL;
					end
				end
			end
		end
	end

	// ***************************************************************
	// Instruction decode, chain choice and Level-2 commands
	// ***************************************************************
	always @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			chain <= `CH_IR;
			unparkRequest <= 1'b0;
			parkRequest <= 3'h0;
			signatureRun <= 1'b0;
			counterRun <= 1'b0;
		end else if (tckRise) begin
			unparkRequest <= 1'b0;
			parkRequest <= 3'h0;
			if (tapState == `TAP_TLR) begin
				chain <= `CH_IR;
				parkRequest <= 3'h1;
			end else if (inUpdateIr && selectState == `SEL_WAIT) begin
				chain <= `CH_ID;
			end else if (inUpdateIr && selected) begin
				case (irShift)
					`OP_BYPASS: chain <= `CH_BYP;
					`OP_EXTEST, `OP_SAMPLE: chain <= `CH_BSR;
					`OP_MODESEL: chain <= `CH_MODE;
					`OP_GROUPSEL: chain <= (selectState == `SEL_SINGLE) ? `CH_GRP : `CH_ID;
					`OP_SIGSEL: chain <= `CH_SIG;
					`OP_CNTSEL: chain <= `CH_CNT;
					default: chain <= `CH_ID;
				endcase
				case (irShift)
					`OP_UNPARK: unparkRequest <= 1'b1;
					`OP_PARKTLR, `OP_WAIT, `OP_SOFTRESET: parkRequest <= 3'h1;
					`OP_PARKRTI: parkRequest <= 3'h2;
					`OP_PARKPAUSE: parkRequest <= 3'h4;
					`OP_SIGON: signatureRun <= 1'b1;
					`OP_SIGOFF: signatureRun <= 1'b0;
					`OP_CNTON: counterRun <= 1'b1;
					`OP_CNTOFF: counterRun <= 1'b0;
					default: ;
				endcase
			end
		end
	end

	// ***************************************************************
	// Backplane serial output, changed on the falling test clock edge
	// ***************************************************************
	reg chainOut;
	always @* begin
		case (chain)
			`CH_BYP: chainOut = bypassBit;
			`CH_BSR: chainOut = bsShift[0];
			`CH_ID: chainOut = idShift[0];
			`CH_GRP: chainOut = grpOut;
			`CH_MODE: chainOut = modeOut;
			`CH_SIG: chainOut = sigShift[0];
			`CH_CNT: chainOut = cntShift[0];
			default: chainOut = irOut;
		endcase
	end
	wire shifting = (tapState == `TAP_SHIR) || (tapState == `TAP_SHDR);
	always @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			backplaneSerialOut <= 1'b0;
			backplaneSerialOutEnable <= 1'b0;
		end else if (tckFall) begin
			backplaneSerialOut <= (tapState == `TAP_SHIR) ? irOut : chainOut;
			backplaneSerialOutEnable <= shifting && (selectState == `SEL_SINGLE);
		end
	end
endmodule

//--- rtl/scan_select_defines.vh
// Constants for the multidrop scan selection logic
`ifndef SCAN_SELECT_DEFINES_VH
`define SCAN_SELECT_DEFINES_VH
`define IR_WIDTH 8
`define ADDR_BROADCAST 6'h3b
`define ADDR_GROUP_BASE 6'h3c
`define ADDR_DIRECT_MAX 6'h3a
`define OP_BYPASS 8'hff
`define OP_EXTEST 8'h00
`define OP_SAMPLE 8'h81
`define OP_IDCODE 8'haa
`define OP_UNPARK 8'he7
`define OP_PARKTLR 8'hc5
`define OP_PARKRTI 8'h84
`define OP_PARKPAUSE 8'hc6
`define OP_WAIT 8'hc3
`define OP_MODESEL 8'h8e
`define OP_GROUPSEL 8'h03
`define OP_SOFTRESET 8'h88
`define OP_SIGSEL 8'hc9
`define OP_SIGON 8'h0c
`define OP_SIGOFF 8'h8d
`define OP_CNTSEL 8'hce
`define OP_CNTON 8'h0f
`define OP_CNTOFF 8'h90
`define IR_CAPTURE 8'h01
`define SEL_WAIT 2'h0
`define SEL_SINGLE 2'h1
`define SEL_MULTI 2'h2
`define SEL_UNSEL 2'h3
`define TAP_TLR 4'hf
`define TAP_RTI 4'hc
`define TAP_SELDR 4'h7
`define TAP_CAPDR 4'h6
`define TAP_SHDR 4'h2
`define TAP_EX1DR 4'h1
`define TAP_PDR 4'h3
`define TAP_EX2DR 4'h0
`define TAP_UPDR 4'h5
`define TAP_SELIR 4'h4
`define TAP_CAPIR 4'he
`define TAP_SHIR 4'ha
`define TAP_EX1IR 4'h9
`define TAP_PIR 4'hb
`define TAP_EX2IR 4'h8
`define TAP_UPIR 4'hd
`define CH_IR 3'h0
`define CH_BYP 3'h1
`define CH_BSR 3'h2
`define CH_ID 3'h3
`define CH_GRP 3'h4
`define CH_MODE 3'h5
`define CH_SIG 3'h6
`define CH_CNT 3'h7
`endif

//--- rtl/scan_shift_reg.v
// Generic capture/shift/update data register entered at its msb
`timescale 1ns/10ps
module scan_shift_reg #(
	parameter WIDTH = 8,
	parameter [WIDTH-1:0] RESET_VALUE = {WIDTH{1'b0}}
) (
	input wire clock,
	input wire nrst,
	input wire step,
	input wire capture,
	input wire shift,
	input wire update,
	input wire [WIDTH-1:0] captureValue,
	input wire serialIn,
	output wire serialOut,
	output reg [WIDTH-1:0] shiftValue,
	output reg [WIDTH-1:0] parallelOut
);
	assign serialOut = shiftValue[0];
	always @(posedge clock or negedge nrst) begin
		if (!nrst) begin
			shiftValue <= RESET_VALUE;
			parallelOut <= RESET_VALUE;
		end else if (step) begin
			if (capture) begin
				shiftValue <= captureValue;
			end else if (shift) begin
				shiftValue <= {serialIn, shiftValue[WIDTH-1:1]};
			end
			if (update) begin
				parallelOut <= shiftValue;
			end
		end
	end
endmodule

//--- bench/scan_tester_model.sv
// Behavioural backplane scan tester driving the bridge test port
`timescale 1ns/10ps
module scan_tester_model (
	input wire clock,
	output reg tck,
	output reg tms,
	output reg tdi,
	input wire tdo,
	input wire tdoEn
);
	reg sawEn;
	reg b;
	initial begin
		tck = 1'b1;
		tms = 1'b1;
		tdi = 1'b0;
		sawEn = 1'b0;
	end
	// ****************
	// One 64 ns test clock period; the output is read late in the high phase
	// ****************
	task step(input tmsV, input tdiV, output outV);
		begin
			tck <= 1'b0;
			tms <= tmsV;
			tdi <= tdiV;
			repeat (4) @(posedge clock);
			tck <= 1'b1;
			repeat (3) @(posedge clock);
			#1;
			outV = tdoEn ? tdo : 1'bz;
			sawEn = sawEn | (tdoEn === 1'b1);
			@(posedge clock);
		end
	endtask
	// Idle data steps drive the inverse of the last bit so stale data is never read
	task reset_tap;
		integer k;
		begin
			for (k = 0; k < 5; k = k + 1) begin
				step(1'b1, ~tdi, b);
			end
			step(1'b0, ~tdi, b);
		end
	endtask
	// Scan from Run-Test/Idle back to Run-Test/Idle, data lsb first
	task scan(input isIr, input [31:0] din, input integer n, output [31:0] dout, output en);
		integer k;
		begin
			sawEn = 1'b0;
			dout = 32'h0;
			step(1'b1, ~tdi, b);
			if (isIr) begin
				step(1'b1, ~tdi, b);
			end
			step(1'b0, ~tdi, b);
			step(1'b0, ~tdi, b);
			for (k = 0; k < n; k = k + 1) begin
				step(k == n - 1, din[k], b);
				dout[k] = b;
			end
			step(1'b1, ~tdi, b);
			step(1'b0, ~tdi, b);
			en = sawEn;
		end
	endtask
endmodule

//--- bench/multidrop_scan_selection_props.sv
// Concurrent checks on the selection block ports
`timescale 1ns/10ps
`include "scan_select_defines.vh"
module scan_selection_props (
	input wire clock,
	input wire nrst,
	input wire testClock,
	input wire [5:0] slotAddress,
	input wire backplaneSerialOut,
	input wire backplaneSerialOutEnable,
	input wire [1:0] selectState,
	input wire [3:0] tapState
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (!nrst);
	enable_single_a: assert property (backplaneSerialOutEnable |-> selectState == `SEL_SINGLE)
		else $error("serial out driven while not single selected");
	sel_update_a: assert property ($changed(selectState) |-> tapState == `TAP_UPIR || tapState == `TAP_TLR
		|| $past(tapState) == `TAP_UPIR || $past(tapState) == `TAP_TLR) else $error("selection changed off update");
	tlr_wait_a: assert property (tapState == `TAP_RTI && $past(tapState) == `TAP_TLR |-> selectState == `SEL_WAIT)
		else $error("reset state not waiting");
	sel_sticky_a: assert property (selectState != `SEL_WAIT |=> selectState == $past(selectState) || selectState == `SEL_WAIT)
		else $error("selection left other than to waiting");
	tlr_quiet_a: assert property (tapState == `TAP_TLR |-> !backplaneSerialOutEnable)
		else $error("serial out driven in reset state");
	tap_rise_a: assert property ($changed(tapState) |-> $past(testClock))
		else $error("tap state moved without test clock high");
	out_fall_a: assert property ($changed(backplaneSerialOut) |-> !$past(testClock))
		else $error("serial out moved without test clock low");
	slot_direct_a: assert property ($rose(selectState == `SEL_SINGLE) |-> slotAddress <= `ADDR_DIRECT_MAX)
		else $error("single selection on reserved slot");
	group_from_wait_a: assert property ($changed(selectState) && selectState == `SEL_MULTI |-> $past(selectState) == `SEL_WAIT)
		else $error("group selection not from waiting");
	cover property (selectState == `SEL_SINGLE && backplaneSerialOutEnable);
	cover property (selectState == `SEL_MULTI);
	cover property (selectState == `SEL_UNSEL);
endmodule
bind multidrop_scan_selection scan_selection_props props (.clock(clock), .nrst(nrst), .testClock(testClock),
	.slotAddress(slotAddress), .backplaneSerialOut(backplaneSerialOut),
	.backplaneSerialOutEnable(backplaneSerialOutEnable), .selectState(selectState), .tapState(tapState));

//--- bench/testbench.sv
// Self-checking bench for the multidrop scan selection block
`timescale 1ns/10ps
`include "scan_select_defines.vh"
module testbench;
	localparam [31:0] ID_EXP = 32'h12345679; // Arbitrary identification value
	localparam [5:0] SLOT = 6'h05;
	reg clock;
	reg nrst;
	wire tck, tms, tdi, serialOut, serialOutEn;
	wire [1:0] selectState, groupValue;
	wire [3:0] tapState;
	wire [7:0] modeValue;
	wire [2:0] park;
	wire unpark, sigRun, cntRun;
	reg oeN;
	integer fails;
	integer nCompared;
	integer i;
	reg [31:0] dout;
	reg en;
	scan_tester_model tester (.clock(clock), .tck(tck), .tms(tms), .tdi(tdi), .tdo(serialOut), .tdoEn(serialOutEn));
	multidrop_scan_selection #(.ID_VALUE(ID_EXP)) uut (.clock(clock), .nrst(nrst), .testClock(tck),
		.testModeSelect(tms), .backplaneSerialIn(tdi), .slotAddress(SLOT), .outputEnableN(oeN),
		.backplaneSerialOut(serialOut), .backplaneSerialOutEnable(serialOutEn), .selectState(selectState),
		.tapState(tapState), .unparkRequest(unpark), .parkRequest(park), .modeValue(modeValue),
		.groupValue(groupValue), .signatureRun(sigRun), .counterRun(cntRun));
	task check(input string what, input [31:0] seen, input [31:0] exp);
		begin
			nCompared = nCompared + 1;
			if (seen !== exp) begin
				fails = fails + 1;
				$display("unexpected %s: expected %h, seen %h", what, exp, seen);
			end
		end
	endtask
	task close_out;
		begin
			$display("Compared %0d, mismatches %0d", nCompared, fails);
			if (fails == 0 && nCompared > 0) begin
				$display("Run complete: PASS");
			end else begin
				$display("Run complete: FAIL");
			end
			$finish;
		end
	endtask
	task address(input [7:0] a, input [1:0] exp);
		begin
			tester.scan(1'b1, {24'h0, a}, 8, dout, en);
			check("select", {30'h0, selectState}, {30'h0, exp});
		end
	endtask
	// ****************
	// Scenarios
	// ****************
	task t_reset_state;
		begin
			check("select", {30'h0, selectState}, {30'h0, `SEL_WAIT});
			check("tap", {28'h0, tapState}, {28'h0, `TAP_TLR});
			check("enable", {31'h0, serialOutEn}, 32'h0);
		end
	endtask
	task t_direct;
		begin
			for (i = 0; i < 4; i = i + 1) begin
				tester.reset_tap;
				check("select", {30'h0, selectState}, {30'h0, `SEL_WAIT});
				address({i[1:0], SLOT}, `SEL_SINGLE);
			end
			tester.scan(1'b0, 32'h0, 32, dout, en);
			check("ident", dout, ID_EXP);
			check("enable", {31'h0, en}, 32'h1);
			address(`OP_GROUPSEL, `SEL_SINGLE);
			check("ir capture", {24'h0, dout[7:0]}, {24'h0, `IR_CAPTURE});
			tester.scan(1'b0, 32'h2, 2, dout, en);
			check("group", {30'h0, groupValue}, 32'h2);
			address(`OP_WAIT, `SEL_WAIT);
		end
	endtask
	task t_level2;
		begin
			tester.reset_tap;
			address({2'b00, SLOT}, `SEL_SINGLE);
			address(`OP_SAMPLE, `SEL_SINGLE);
			tester.scan(1'b0, 32'h0, 7, dout, en);
			check("boundary", dout, {25'h0, oeN, SLOT});
			address(`OP_BYPASS, `SEL_SINGLE);
			tester.scan(1'b0, 32'h1, 1, dout, en);
			check("bypass", dout, 32'h0);
			address(`OP_MODESEL, `SEL_SINGLE);
			tester.scan(1'b0, 32'h5a, 8, dout, en);
			check("mode", {24'h0, modeValue}, 32'h5a);
			address(`OP_UNPARK, `SEL_SINGLE);
			check("unpark", {31'h0, unpark}, 32'h1);
			address(`OP_PARKRTI, `SEL_SINGLE);
			check("park", {29'h0, park}, 32'h2);
			address(`OP_PARKPAUSE, `SEL_SINGLE);
			check("park", {29'h0, park}, 32'h4);
			address(`OP_SIGON, `SEL_SINGLE);
			check("signature run", {31'h0, sigRun}, 32'h1);
			address(`OP_CNTON, `SEL_SINGLE);
			check("counter run", {31'h0, cntRun}, 32'h1);
			address(`OP_WAIT, `SEL_WAIT);
			check("park", {29'h0, park}, 32'h1);
			address(8'h3a, `SEL_UNSEL);
			address(`OP_SIGOFF, `SEL_UNSEL);
			check("signature run", {31'h0, sigRun}, 32'h1);
			address(`OP_WAIT, `SEL_WAIT);
		end
	endtask
	task t_group;
		begin
			address(8'h3e, `SEL_MULTI);
			address(`OP_BYPASS, `SEL_MULTI);
			check("enable", {31'h0, en}, 32'h0);
			address(`OP_WAIT, `SEL_WAIT);
			address(8'h3d, `SEL_UNSEL);
			address({2'b00, SLOT}, `SEL_UNSEL);
			check("enable", {31'h0, en}, 32'h0);
			address(`OP_WAIT, `SEL_WAIT);
			address(8'h3a, `SEL_UNSEL);
			tester.reset_tap;
			address(8'hbb, `SEL_MULTI);
			address(`OP_IDCODE, `SEL_MULTI);
			check("enable", {31'h0, en}, 32'h0);
			tester.reset_tap;
			check("select", {30'h0, selectState}, {30'h0, `SEL_WAIT});
		end
	endtask
	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end
	initial begin
		#700000;
		fails = fails + 1;
		close_out;
	end
	initial begin
		fails = 0;
		nCompared = 0;
		oeN = 1'b1;
		nrst = 1'b0;
		repeat (10) @(posedge clock);
		t_reset_state;
		nrst <= 1'b1;
		repeat (4) @(posedge clock);
		t_direct;
		t_level2;
		t_group;
		close_out;
	end
endmodule
